// File: frar_pkg.sv
`default_nettype none

package frar_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] FIELDS_LO_OFF = 8'h00;
    localparam logic [7:0] FIELDS_HI_OFF = 8'h04;
    localparam logic [7:0] SYS_CFG_OFF = 8'h08;
    localparam logic [7:0] STATUS_OFF = 8'h0c;
    localparam logic [7:0] MEM_COUNT_OFF = 8'h10;
    localparam logic [7:0] MMIO_COUNT_OFF = 8'h14;
    localparam int OFF_W = 8;

    // ==========================================================
    // Type field layout, one byte per field
    localparam int NUM_FIELDS = 8;
    localparam int FIELD_W = 8;
    localparam int TYPE_LSB = 0;
    localparam int TYPE_W = 3;
    localparam int WR_MEM_BIT = 3;
    localparam int RD_MEM_BIT = 4;
    localparam logic [7:0] FIELD_RST = 8'h00;

    // ==========================================================
    // System configuration and status bits
    localparam int ROUTE_EN_BIT = 18;
    localparam int MOD_EN_BIT = 19;
    localparam int CFG_BYTE = 2;
    localparam logic CFG_EN_RST = 1'b0;
    localparam int ST_RESERVED_BIT = 0;
    localparam int ST_LAST_MEM_BIT = 1;
    localparam int ST_LAST_TYPE_LSB = 4;

    // ==========================================================
    // Fixed range: eight 64 KB segments starting at zero
    localparam int SEG_SHIFT = 16;
    localparam int IDX_W = 3;
    localparam int RANGE_HI_LSB = SEG_SHIFT + IDX_W;

    // ==========================================================
    // Memory type codes
    localparam logic [2:0] UNCACHEABLE_TYPE = 3'h0;
    localparam logic [2:0] WRITE_COMBINING_TYPE = 3'h1;
    localparam logic [2:0] WRITETHROUGH_TYPE = 3'h4;
    localparam logic [2:0] WRITE_PROTECT_TYPE = 3'h5;
    localparam logic [2:0] WRITEBACK_TYPE = 3'h6;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } frar_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } frar_axil_rsp_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
    } frar_access_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic in_range;
        logic to_memory;
        logic [TYPE_W-1:0] mem_type;
        logic reserved;
    } frar_route_t;

endpackage

`default_nettype wire

// File: frar_router.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Write routing bit 1 sends writes to memory
// R2: Read routing bit 1 sends reads to memory
// R3: Routing bits at 4:3, type at 2:0
// R4: Route enable 0 sends everything to I/O
// R5: Modify enable 0: routing bits frozen, read 0
// R6: Routing 00 allows types 0,1,4,5 only
// R7: Write-only memory routing allows type 0 only
// R8: Read-only memory routing allows types 0,5
// R9: Both routing bits allow types 0,1,4,6
// R10: Software avoids reserved routing/type pairs
// R11: Software sets modify, fields, then route enable
// R12: Software shadows ROM by two-step routing change
// R13: Software keeps page mappings consistently cacheable
// R14: Software remaps pages and flushes translation buffers
// R15: Software flushes caches on cacheable-to-uncacheable change
// R16: Stored routing bits survive cleared enables
module frar_router (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire frar_pkg::frar_axil_req_t axil_req,
    output frar_pkg::frar_axil_rsp_t axil_rsp,
    // Processor access and routing decision
    input wire frar_pkg::frar_access_t access,
    output frar_pkg::frar_route_t route
);
    import frar_pkg::*;

    // ==========================================================
    // Combination checks
    function automatic logic combo_reserved(input logic rd, input logic wr,
                                            input logic [2:0] t);
        logic res;
        res = 1'b1;
        unique case ({rd, wr})
            2'b00: res = !(t == UNCACHEABLE_TYPE || t == WRITE_COMBINING_TYPE ||
                           t == WRITETHROUGH_TYPE || t == WRITE_PROTECT_TYPE); // R6
            2'b01: res = (t != UNCACHEABLE_TYPE); // R7
            2'b10: res = !(t == UNCACHEABLE_TYPE || t == WRITE_PROTECT_TYPE); // R8
            2'b11: res = !(t == UNCACHEABLE_TYPE || t == WRITE_COMBINING_TYPE ||
                           t == WRITETHROUGH_TYPE || t == WRITEBACK_TYPE); // R9
        endcase
        return res;
    endfunction

    // Routing bits only change while modification is allowed
    function automatic logic [7:0] field_merge(input logic [7:0] old, input logic [7:0] wd,
                                               input logic mod_en);
        logic [7:0] nv;
        nv = FIELD_RST;
        nv[TYPE_LSB +: TYPE_W] = wd[TYPE_LSB +: TYPE_W]; // R3
        nv[WR_MEM_BIT] = mod_en ? wd[WR_MEM_BIT] : old[WR_MEM_BIT]; // R5
        nv[RD_MEM_BIT] = mod_en ? wd[RD_MEM_BIT] : old[RD_MEM_BIT]; // R5
        return nv;
    endfunction

    function automatic logic [7:0] field_view(input logic [7:0] f, input logic mod_en);
        logic [7:0] v;
        v = f;
        if (!mod_en) begin
            v[WR_MEM_BIT] = 1'b0; // R5
            v[RD_MEM_BIT] = 1'b0; // R5
        end
        return v;
    endfunction

    // ==========================================================
    // State
    logic [FIELD_W-1:0] field_q [NUM_FIELDS];
    logic route_en_q;
    logic mod_en_q;
    logic reserved_hit_q;
    logic [DATA_W-1:0] mem_count_q;
    logic [DATA_W-1:0] mmio_count_q;
    logic aw_full_q;
    logic [OFF_W-1:0] aw_off_q;
    logic aw_hi_q;
    logic w_full_q;
    logic [DATA_W-1:0] w_data_q;
    logic [STRB_W-1:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    frar_route_t route_q;

    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_commit;
    logic wr_fields;
    logic wr_okay;
    logic [OFF_W-1:0] ar_off;
    logic ar_hi;
    logic [DATA_W-1:0] rd_word;
    logic rd_okay;

    // ==========================================================
    // Write channel: address and data taken in either order
    assign aw_take = axil_req.awvalid && !aw_full_q;
    assign w_take = axil_req.wvalid && !w_full_q;
    assign wr_commit = aw_full_q && w_full_q && !bvalid_q;
    assign wr_fields = (aw_off_q == FIELDS_LO_OFF) || (aw_off_q == FIELDS_HI_OFF);
    assign wr_okay = wr_fields || aw_off_q == SYS_CFG_OFF || aw_off_q == STATUS_OFF ||
                     aw_off_q == MEM_COUNT_OFF || aw_off_q == MMIO_COUNT_OFF;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_off_q <= '0;
            aw_hi_q <= 1'b0;
        end else if (aw_take) begin
            aw_full_q <= 1'b1;
            aw_off_q <= (axil_req.awaddr[ADDR_W-1:OFF_W] == '0) ?
                        axil_req.awaddr[OFF_W-1:0] : 8'hff;
            aw_hi_q <= (axil_req.awaddr[OFF_W-1:0] == FIELDS_HI_OFF);
        end else if (wr_commit) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (w_take) begin
            w_full_q <= 1'b1;
            w_data_q <= axil_req.wdata;
            w_strb_q <= axil_req.wstrb;
        end else if (wr_commit) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_commit) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_okay ? RESP_OKAY : RESP_SLVERR;
        end else if (axil_req.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Type fields; routing bits kept whatever the enables do
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_FIELDS; i++) begin
                field_q[i] <= FIELD_RST;
            end
        end else if (wr_commit && wr_fields) begin
            for (int i = 0; i < STRB_W; i++) begin
                if (w_strb_q[i]) begin
                    field_q[{aw_hi_q, 2'(i)}] <= field_merge(field_q[{aw_hi_q, 2'(i)}],
                        w_data_q[8*i +: 8], mod_en_q); // R16
                end
            end
        end
    end

    // ==========================================================
    // System configuration enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_en_q <= CFG_EN_RST;
            mod_en_q <= CFG_EN_RST;
        end else if (wr_commit && aw_off_q == SYS_CFG_OFF && w_strb_q[CFG_BYTE]) begin
            route_en_q <= w_data_q[ROUTE_EN_BIT];
            mod_en_q <= w_data_q[MOD_EN_BIT];
        end
    end

    // ==========================================================
    // Read channel, answered one cycle after the address
    assign ar_take = axil_req.arvalid && !rvalid_q;
    assign ar_off = axil_req.araddr[OFF_W-1:0];
    assign ar_hi = (ar_off == FIELDS_HI_OFF);

    always_comb begin
        rd_word = '0;
        rd_okay = (axil_req.araddr[ADDR_W-1:OFF_W] == '0);
        unique case (ar_off)
            FIELDS_LO_OFF, FIELDS_HI_OFF: begin
                for (int i = 0; i < STRB_W; i++) begin
                    rd_word[8*i +: 8] = field_view(field_q[{ar_hi, 2'(i)}], mod_en_q);
                end
            end
            SYS_CFG_OFF: begin
                rd_word[ROUTE_EN_BIT] = route_en_q;
                rd_word[MOD_EN_BIT] = mod_en_q;
            end
            STATUS_OFF: begin
                rd_word[ST_RESERVED_BIT] = reserved_hit_q;
                rd_word[ST_LAST_MEM_BIT] = route_q.to_memory;
                rd_word[ST_LAST_TYPE_LSB +: TYPE_W] = route_q.mem_type;
            end
            MEM_COUNT_OFF: rd_word = mem_count_q;
            MMIO_COUNT_OFF: rd_word = mmio_count_q;
            default: rd_okay = 1'b0;
        endcase
        if (!rd_okay) begin
            rd_word = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_okay ? RESP_OKAY : RESP_SLVERR;
        end else if (axil_req.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign axil_rsp.awready = !aw_full_q;
    assign axil_rsp.wready = !w_full_q;
    assign axil_rsp.bvalid = bvalid_q;
    assign axil_rsp.bresp = bresp_q;
    assign axil_rsp.arready = !rvalid_q;
    assign axil_rsp.rvalid = rvalid_q;
    assign axil_rsp.rdata = rdata_q;
    assign axil_rsp.rresp = rresp_q;

    // ==========================================================
    // Access routing, one cycle from request to decision
    logic acc_in_range;
    logic [FIELD_W-1:0] acc_field;
    logic eff_rd;
    logic eff_wr;
    logic dec_mem;
    logic dec_res;

    assign acc_in_range = (access.addr[ADDR_W-1:RANGE_HI_LSB] == '0);
    assign acc_field = field_q[access.addr[SEG_SHIFT +: IDX_W]];
    // Disabled routing bits act as zero but stay stored
    assign eff_rd = route_en_q && acc_field[RD_MEM_BIT]; // R4
    assign eff_wr = route_en_q && acc_field[WR_MEM_BIT]; // R4
    assign dec_mem = acc_in_range && (access.write ? eff_wr : eff_rd); // R1 R2
    // Reserved pairs are only flagged; the routing follows the bits anyway
    assign dec_res = acc_in_range &&
                     combo_reserved(eff_rd, eff_wr, acc_field[TYPE_LSB +: TYPE_W]); // R10

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_q <= '0;
        end else begin
            route_q.valid <= access.valid;
            if (access.valid) begin
                route_q.write <= access.write;
                route_q.in_range <= acc_in_range;
                route_q.to_memory <= dec_mem;
                route_q.mem_type <= acc_in_range ? acc_field[TYPE_LSB +: TYPE_W] :
                                    UNCACHEABLE_TYPE;
                route_q.reserved <= dec_res;
            end
        end
    end

    assign route = route_q;

    // ==========================================================
    // Sticky reserved-hit flag: a new hit beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reserved_hit_q <= 1'b0;
        end else if (access.valid && dec_res) begin
            reserved_hit_q <= 1'b1;
        end else if (wr_commit && aw_off_q == STATUS_OFF && w_strb_q[0] &&
                     w_data_q[ST_RESERVED_BIT]) begin
            reserved_hit_q <= 1'b0;
        end
    end

    // In-range access counters, free running and wrapping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_count_q <= '0;
            mmio_count_q <= '0;
        end else if (access.valid && acc_in_range) begin
            if (dec_mem) begin
                mem_count_q <= mem_count_q + 32'h1;
            end else begin
                mmio_count_q <= mmio_count_q + 32'h1;
            end
        end
    end

endmodule

`default_nettype wire

// File: frar_router_sva.sv
`timescale 1ns/1ps
`default_nettype none
module frar_router_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Watched ports
    input wire frar_pkg::frar_axil_req_t axil_req,
    input wire frar_pkg::frar_axil_rsp_t axil_rsp,
    input wire frar_pkg::frar_access_t access,
    input wire frar_pkg::frar_route_t route
);
    import frar_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ====
    // Register bus
    sequence s_aw_w;
        axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
    endsequence
    sequence s_ar;
        axil_req.arvalid && axil_rsp.arready;
    endsequence
    property p_wr_ans;
        // Commit takes one edge after the handshake, the answer shows the edge after that
        s_aw_w |=> ##1 axil_rsp.bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_b_hold;
        axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid && $stable(axil_rsp.bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_rd_ans;
        s_ar |=> axil_rsp.rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_r_hold;
        axil_rsp.rvalid && !axil_req.rready |=> axil_rsp.rvalid && $stable(axil_rsp.rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_ar_refuse;
        axil_rsp.rvalid |-> !axil_rsp.arready;
    endproperty
    a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
    // ====
    // Routing decision
    property p_rt_valid;
        $past(aresetn) |-> route.valid == $past(access.valid);
    endproperty
    a_rt_valid: assert property (p_rt_valid) else $error("decision not one cycle later");
    property p_rt_dir;
        access.valid |=> route.write == $past(access.write)
            && route.in_range == ($past(access.addr[31:19]) == 13'h0);
    endproperty
    a_rt_dir: assert property (p_rt_dir) else $error("decision for wrong access");
    property p_out_io;
        route.valid && !route.in_range |-> !route.to_memory;
    endproperty
    a_out_io: assert property (p_out_io) else $error("outside range sent to memory");
    property p_res_type;
        route.valid && route.mem_type inside {3'h2, 3'h3, 3'h7} |-> route.reserved;
    endproperty
    a_res_type: assert property (p_res_type) else $error("undefined type not flagged");
    // A write sent to memory means write routing 1, where type 5 is never allowed
    property p_res_wp;
        route.valid && route.write && route.to_memory
            && route.mem_type == WRITE_PROTECT_TYPE |-> route.reserved;
    endproperty
    a_res_wp: assert property (p_res_wp) else $error("type 5 pair not flagged");
endmodule
bind frar_router frar_router_sva i_sva (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
    .axil_rsp(axil_rsp), .access(access), .route(route));
`default_nettype wire

// File: frar_paths.sv
`timescale 1ns/1ps
`default_nettype none
module frar_paths (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Routing decisions
    input wire frar_pkg::frar_route_t route,
    // Deliveries per path
    output logic [15:0] mem_hits,
    output logic [15:0] io_hits
);
    import frar_pkg::*;
    logic [15:0] mem_hits_q;
    logic [15:0] io_hits_q;
    // ====
    // Each decision lands on exactly one path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_hits_q <= 16'h0;
            io_hits_q <= 16'h0;
        end else if (route.valid && route.to_memory) begin
            mem_hits_q <= mem_hits_q + 16'h1;
        end else if (route.valid) begin
            io_hits_q <= io_hits_q + 16'h1;
        end
    end
    assign mem_hits = mem_hits_q;
    assign io_hits = io_hits_q;
endmodule
`default_nettype wire

// File: fixed_range_access_router_test.sv
`timescale 1ns/1ps
`default_nettype none
module fixed_range_access_router_test;
    import frar_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    frar_axil_req_t req = '0;
    frar_axil_rsp_t rsp;
    frar_access_t acc = '0;
    frar_route_t rt;
    logic [15:0] mem_hits;
    logic [15:0] io_hits;
    int n_fail = 0;
    int n_checks = 0;
    int seed = 32'ha0f0;
    int e_mem = 0;
    int e_io = 0;
    int e_io_in = 0;
    logic e_hit = 1'b0;
    logic l_m = 1'b0;
    logic [2:0] l_t = 3'h0;
    logic [4:0] fld [NUM_FIELDS];
    logic ren = 1'b0;
    logic men = 1'b0;
    logic [31:0] rd_d;

    frar_router i_dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
        .access(acc), .route(rt));
    frar_paths i_paths (.aclk(aclk), .aresetn(aresetn), .route(rt), .mem_hits(mem_hits),
        .io_hits(io_hits));

    initial begin
        forever #12.5 aclk = ~aclk;
    end
    // ====
    // Checking and bus tasks
    task automatic tally_and_finish();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Ready is raised late on purpose so the slave must hold its answer
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int i;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid && req.bready) break;
            if (rsp.bvalid) req.bready <= 1'b1;
        end
        req.bready <= 1'b0;
        if (i == 40) begin
            n_fail++;
            tally_and_finish();
        end
        chk(32'(rsp.bresp), 32'(er));
    endtask
    task automatic rd(input logic [31:0] a, input logic [1:0] er);
        int i;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid && req.rready) break;
            if (rsp.rvalid) req.rready <= 1'b1;
        end
        req.rready <= 1'b0;
        if (i == 40) begin
            n_fail++;
            tally_and_finish();
        end
        rd_d = rsp.rdata;
        chk(32'(rsp.rresp), 32'(er));
    endtask
    // ====
    // Expectations
    function automatic logic res_of(input logic [4:0] f);
        case (f[4:3])
            2'b00: return !(f[2:0] inside {3'h0, 3'h1, 3'h4, 3'h5});
            2'b01: return f[2:0] != 3'h0;
            2'b10: return !(f[2:0] inside {3'h0, 3'h5});
            default: return !(f[2:0] inside {3'h0, 3'h1, 3'h4, 3'h6});
        endcase
    endfunction
    task automatic cfg(input logic r, input logic m);
        wr({24'h0, SYS_CFG_OFF}, {12'h0, m, r, 18'h0}, 4'h4, RESP_OKAY);
        ren = r;
        men = m;
    endtask
    task automatic put(input int i, input logic [4:0] f);
        wr(i < 4 ? 32'h0 : 32'h4, 32'(f) << (8 * (i % 4)), 4'(1 << (i % 4)), RESP_OKAY);
        fld[i] = men ? f : {fld[i][4:3], f[2:0]};
    endtask
    task automatic look(input int i);
        rd(i < 4 ? 32'h0 : 32'h4, RESP_OKAY);
        chk(32'(rd_d[8 * (i % 4) +: 8]), 32'(men ? fld[i] : {2'b0, fld[i][2:0]}));
    endtask
    task automatic go(input logic w, input logic [31:0] a);
        logic [4:0] f;
        logic inr;
        logic m;
        logic r;
        f = fld[a[18:16]];
        inr = a[31:19] == 13'h0;
        m = inr && ren && (w ? f[3] : f[4]);
        // With routing disabled the pair in force is 00, whatever is stored
        r = res_of({ren ? f[4:3] : 2'b00, f[2:0]});
        @(posedge aclk);
        acc <= '{valid: 1'b1, write: w, addr: a};
        @(posedge aclk);
        acc.valid <= 1'b0;
        #1;
        chk(32'({rt.valid, rt.write, rt.in_range}), 32'({1'b1, w, inr}));
        chk(32'(rt.to_memory), 32'(m));
        if (inr) chk(32'({rt.mem_type, rt.reserved}), 32'({f[2:0], r}));
        if (m) e_mem++;
        else e_io++;
        if (inr && !m) e_io_in++;
        if (inr && r) e_hit = 1'b1;
        l_m = m;
        l_t = inr ? f[2:0] : 3'h0;
    endtask
    // ====
    // Main sequence
    initial begin
        int i;
        for (i = 0; i < NUM_FIELDS; i++) fld[i] = 5'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd({24'h0, SYS_CFG_OFF}, RESP_OKAY);
        chk(rd_d, 32'h0);
        look(0);
        cfg(1'b0, 1'b1);
        for (i = 0; i < NUM_FIELDS; i++) put(i, 5'($random(seed)));
        for (i = 0; i < NUM_FIELDS; i++) look(i);
        cfg(1'b1, 1'b1);
        repeat (40) go(1'($random(seed)), 32'($random(seed)) & 32'h000fffff);
        cfg(1'b1, 1'b0);
        put(2, 5'h1d);
        look(2);
        go(1'b1, 32'h00020010);
        go(1'b0, 32'h00020010);
        cfg(1'b0, 1'b0);
        go(1'b1, 32'h00020000);
        go(1'b0, 32'h00020000);
        cfg(1'b1, 1'b1);
        look(2);
        // Every routing pair with every type; steps 8 then 16 are the shadowing pair
        for (i = 0; i < 32; i++) begin
            put(5, 5'(i));
            go(1'b1, 32'h00051234);
            go(1'b0, 32'h00051234);
        end
        wr(32'h00000018, 32'hffffffff, 4'hf, RESP_SLVERR);
        rd(32'h00000100, RESP_SLVERR);
        chk(rd_d, 32'h0);
        // Status, its sticky clear, and the in-range counters
        rd({24'h0, STATUS_OFF}, RESP_OKAY);
        chk(rd_d, {25'h0, l_t, 2'b0, l_m, e_hit});
        wr({24'h0, STATUS_OFF}, 32'h1, 4'h1, RESP_OKAY);
        rd({24'h0, STATUS_OFF}, RESP_OKAY);
        chk(rd_d, {25'h0, l_t, 2'b0, l_m, 1'b0});
        rd({24'h0, MEM_COUNT_OFF}, RESP_OKAY);
        chk(rd_d, 32'(e_mem));
        rd({24'h0, MMIO_COUNT_OFF}, RESP_OKAY);
        chk(rd_d, 32'(e_io_in));
        repeat (2) @(posedge aclk);
        chk(32'(mem_hits), 32'(e_mem));
        chk(32'(io_hits), 32'(e_io));
        tally_and_finish();
    end
endmodule
`default_nettype wire
